// *** alo_pkg.sv ***
/*
 * alo_pkg: shared constants and types of the add/and datapath.
 * assumes a 32-bit classic wishbone register bus and a 14-bit instruction word.
 */
package alo_pkg;

    // datapath geometry
    localparam int DATA_W      = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int INSTR_W     = 14;
    localparam int WB_ADR_W    = 8;

    // one instruction cycle is four oscillator periods
    localparam int        INSTR_CLKS = 4;
    localparam logic [1:0] PHASE_LAST = 2'(INSTR_CLKS - 1);

    // register byte offsets
    localparam logic [7:0] REG_INSTR     = 8'h00;
    localparam logic [7:0] REG_ACC       = 8'h04;
    localparam logic [7:0] REG_FLAGS     = 8'h08;
    localparam logic [7:0] REG_FILE_PTR  = 8'h0C;
    localparam logic [7:0] REG_FILE_DATA = 8'h10;

    // flags register fields
    localparam int FLG_CARRY_BIT = 0;
    localparam int FLG_HALF_BIT  = 1;
    localparam int FLG_ZERO_BIT  = 2;
    localparam int FLG_BUSY_BIT  = 8;
    localparam int FLG_BAD_BIT   = 9;

    // reset values
    localparam logic [13:0] INSTR_RST = 14'h0000;
    localparam logic [7:0]  ACC_RST   = 8'h00;
    localparam logic [6:0]  PTR_RST   = 7'h00;
    localparam logic [7:0]  FILE_RST  = 8'h00;

    // opcode field patterns
    localparam logic [4:0] OPC_ADD_LIT  = 5'h1F;
    localparam logic [5:0] OPC_AND_LIT  = 6'h39;
    localparam logic [5:0] OPC_ADD_FILE = 6'h07;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam int         DEST_BIT     = 7;

    typedef enum logic [2:0] {
        ins_other,
        add_literal_to_acc,
        and_literal_with_acc,
        add_acc_to_file,
        and_acc_with_file
    } alo_instr_t;

    typedef enum logic {
        ALU_ADD,
        ALU_AND
    } alo_aluop_t;

    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } alo_state_t;

endpackage : alo_pkg

// *** alo_alu.sv ***
/*
 * alo_alu: combinational 8-bit add / and with carry, half carry and zero.
 * assumes the caller decides which flags are kept.
 */
`timescale 1ns/1ps
module alo_alu
    import alo_pkg::*;
#(
    parameter int W = DATA_W
) (
    // operation and operands
    input  wire alo_aluop_t   op_i,
    input  wire logic [W-1:0] a_i,
    input  wire logic [W-1:0] b_i,
    // result and flags
    output logic [W-1:0]      res_o,
    output logic              carry_o,
    output logic              half_carry_flag_o,
    output logic              zero_o
);

    logic [W:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum     = {1'b0, a_i} + {1'b0, b_i};
        low_sum = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        if (op_i == ALU_ADD) begin
            res_o = sum[W-1:0];
        end else begin
            res_o = a_i & b_i;
        end
        carry_o           = sum[W];
        half_carry_flag_o = low_sum[4];
        zero_o            = (res_o == '0);
    end

endmodule : alo_alu

// *** alo_file_bank.sv ***
/*
 * alo_file_bank: file registers held in flip-flops, one write, one read port.
 * assumes the caller muxes addresses; read is combinational.
 */
`timescale 1ns/1ps
module alo_file_bank
    import alo_pkg::*;
#(
    parameter int AW = FILE_ADDR_W,
    parameter int DW = DATA_W
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // write port
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    // read port
    input  wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0]      rdata_o
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem[i] <= DW'(FILE_RST);
            end
        end else if (ce_i && we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem[raddr_i];

endmodule : alo_file_bank

// *** alo_core.sv ***
/*
 * alo_core: executes four accumulator instructions written over wishbone.
 * assumes a classic wishbone master; one clock is the oscillator.
 */
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module alo_core
    import alo_pkg::*;
(
    // clock, reset, enable
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    // status
    output logic                     busy_o,
    output logic [DATA_W-1:0]        acc_o
);

    alo_state_t             state;
    logic [1:0]             phase;
    logic [INSTR_W-1:0]     instr;
    logic [DATA_W-1:0]      acc;
    logic                   carry;
    logic                   half_carry_flag;
    logic                   zero;
    logic                   bad_op;
    logic [FILE_ADDR_W-1:0] file_ptr;

    logic                   bus_req;
    logic                   bus_wr;
    logic [15:0]            wmask;
    logic                   commit;
    alo_instr_t             dec;
    alo_aluop_t             alu_op;
    logic [DATA_W-1:0]      operand;
    logic [DATA_W-1:0]      alu_res;
    logic                   alu_c;
    logic                   alu_hc;
    logic                   alu_z;
    logic                   dest_file;
    logic                   file_we;
    logic [FILE_ADDR_W-1:0] file_waddr;
    logic [DATA_W-1:0]      file_wdata;
    logic [FILE_ADDR_W-1:0] file_raddr;
    logic [DATA_W-1:0]      file_rdata;
    logic [31:0]            next_rdata;
    logic [13:0]            next_instr;

    // request seen once; ack rises the next edge and drops after
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;
    assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign commit  = (state == ST_EXEC) && (phase == PHASE_LAST);

    // opcode decode
    always_comb begin
        dec = ins_other;
        if (instr[13:9] == OPC_ADD_LIT) begin
            dec = add_literal_to_acc;
        end else if (instr[13:8] == OPC_AND_LIT) begin
            dec = and_literal_with_acc;
        end else if (instr[13:8] == OPC_ADD_FILE) begin
            dec = add_acc_to_file;
        end else if (instr[13:8] == OPC_AND_FILE) begin
            dec = and_acc_with_file;
        end
    end

    // operand select
    always_comb begin
        alu_op    = ALU_AND;
        operand   = instr[DATA_W-1:0];
        dest_file = 1'b0;
        case (dec)
            add_literal_to_acc: begin
                alu_op = ALU_ADD;
            end
            and_literal_with_acc: begin
                alu_op = ALU_AND;
            end
            add_acc_to_file: begin
                alu_op    = ALU_ADD;
                operand   = file_rdata;
                dest_file = instr[DEST_BIT];
            end
            and_acc_with_file: begin
                alu_op    = ALU_AND;
                operand   = file_rdata;
                dest_file = instr[DEST_BIT];
            end
            default: begin
                alu_op = ALU_AND;
            end
        endcase
    end

    alo_alu #(
        .W (DATA_W)
    ) u_alu (
        .op_i              (alu_op),
        .a_i               (acc),
        .b_i               (operand),
        .res_o             (alu_res),
        .carry_o           (alu_c),
        .half_carry_flag_o (alu_hc),
        .zero_o            (alu_z)
    );

    // file port muxing; execution owns the bank while busy
    always_comb begin
        file_raddr = file_ptr;
        file_we    = 1'b0;
        file_waddr = file_ptr;
        file_wdata = wb_dat_i[DATA_W-1:0];
        if (state == ST_EXEC) begin
            file_raddr = instr[FILE_ADDR_W-1:0];
            file_waddr = instr[FILE_ADDR_W-1:0];
            file_wdata = alu_res;
            file_we    = commit && dest_file &&
                         (dec == add_acc_to_file || dec == and_acc_with_file);
        end else begin
            file_we = bus_wr && (wb_adr_i == REG_FILE_DATA) && wb_sel_i[0];
        end
    end

    alo_file_bank #(
        .AW (FILE_ADDR_W),
        .DW (DATA_W)
    ) u_bank (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .we_i    (file_we),
        .waddr_i (file_waddr),
        .wdata_i (file_wdata),
        .raddr_i (file_raddr),
        .rdata_o (file_rdata)
    );

    // sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            phase <= 2'h0;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    phase <= 2'h0;
                    if (bus_wr && wb_adr_i == REG_INSTR && (wb_sel_i[1] || wb_sel_i[0])) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (phase == PHASE_LAST) begin
                        state <= ST_IDLE;
                        phase <= 2'h0;
                    end else begin
                        phase <= phase + 2'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // instruction latch; writes refused while busy
    assign next_instr = (instr & ~wmask[13:0]) | (wb_dat_i[13:0] & wmask[13:0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr <= INSTR_RST;
        end else if (ce_i && state == ST_IDLE && bus_wr && wb_adr_i == REG_INSTR) begin
            instr <= next_instr;
        end
    end

    // accumulator; execution wins over a bus write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= ACC_RST;
        end else if (ce_i) begin
            if (commit && (dec == add_literal_to_acc || dec == and_literal_with_acc)) begin
                acc <= alu_res;
            end else if (commit && (dec == add_acc_to_file || dec == and_acc_with_file)) begin
                if (!dest_file) begin
                    acc <= alu_res;
                end
            end else if (state == ST_IDLE && bus_wr && wb_adr_i == REG_ACC && wb_sel_i[0]) begin
                acc <= wb_dat_i[DATA_W-1:0];
            end
        end
    end

    // flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry           <= 1'b0;
            half_carry_flag <= 1'b0;
            zero            <= 1'b0;
        end else if (ce_i) begin
            if (commit && (dec == add_literal_to_acc || dec == add_acc_to_file)) begin
                carry           <= alu_c;
                half_carry_flag <= alu_hc;
                zero            <= alu_z;
            end else if (commit && (dec == and_literal_with_acc || dec == and_acc_with_file)) begin
                zero <= alu_z;
            end else if (state == ST_IDLE && bus_wr && wb_adr_i == REG_FLAGS && wb_sel_i[0]) begin
                carry           <= wb_dat_i[FLG_CARRY_BIT];
                half_carry_flag <= wb_dat_i[FLG_HALF_BIT];
                zero            <= wb_dat_i[FLG_ZERO_BIT];
            end
        end
    end

    // unsupported opcode flag; set wins over a clearing write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_op <= 1'b0;
        end else if (ce_i) begin
            if (commit && dec == ins_other) begin
                bad_op <= 1'b1;
            end else if (bus_wr && wb_adr_i == REG_FLAGS && wb_sel_i[1]) begin
                bad_op <= wb_dat_i[FLG_BAD_BIT];
            end
        end
    end

    // file pointer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            file_ptr <= PTR_RST;
        end else if (ce_i && bus_wr && wb_adr_i == REG_FILE_PTR && wb_sel_i[0]) begin
            file_ptr <= wb_dat_i[FILE_ADDR_W-1:0];
        end
    end

    // read mux; unmapped reads as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (wb_adr_i == REG_INSTR) begin
            next_rdata[INSTR_W-1:0] = instr;
        end else if (wb_adr_i == REG_ACC) begin
            next_rdata[DATA_W-1:0] = acc;
        end else if (wb_adr_i == REG_FLAGS) begin
            next_rdata[FLG_CARRY_BIT] = carry;
            next_rdata[FLG_HALF_BIT]  = half_carry_flag;
            next_rdata[FLG_ZERO_BIT]  = zero;
            next_rdata[FLG_BUSY_BIT]  = (state == ST_EXEC);
            next_rdata[FLG_BAD_BIT]   = bad_op;
        end else if (wb_adr_i == REG_FILE_PTR) begin
            next_rdata[FILE_ADDR_W-1:0] = file_ptr;
        end else if (wb_adr_i == REG_FILE_DATA) begin
            // bank belongs to execution while busy
            if (state == ST_IDLE) begin
                next_rdata[DATA_W-1:0] = file_rdata;
            end
        end
    end

    // bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    // status outputs from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            acc_o  <= ACC_RST;
        end else if (ce_i) begin
            busy_o <= (state == ST_EXEC) && !commit ||
                      (state == ST_IDLE && bus_wr && wb_adr_i == REG_INSTR && (wb_sel_i[1] || wb_sel_i[0]));
            if (commit && (dec == add_literal_to_acc || dec == and_literal_with_acc ||
                           ((dec == add_acc_to_file || dec == and_acc_with_file) && !dest_file))) begin
                acc_o <= alu_res;
            end else if (state == ST_IDLE && bus_wr && wb_adr_i == REG_ACC && wb_sel_i[0]) begin
                acc_o <= wb_dat_i[DATA_W-1:0];
            end
        end
    end

endmodule : alo_core

// *** alo_core_assertions.sv ***
/* alo_core_checker: concurrent checks on the ports of alo_core, bound below.
   assumes one clock, synchronous active-high reset, classic wishbone. */
`timescale 1ns/1ps
module alo_core_checker
    import alo_pkg::*;
(
    // clock, reset, enable
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                ce_i,
    // wishbone
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0]          wb_sel_i,
    input wire logic [31:0]         wb_dat_i,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                wb_ack_o,
    // status
    input wire logic                busy_o,
    input wire logic [DATA_W-1:0]   acc_o
);
    logic              take;
    logic              go;
    logic [INSTR_W-1:0] lat_ins;
    logic [DATA_W-1:0]  lat_acc;

    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign go = take && wb_we_i && wb_adr_i == REG_INSTR && wb_sel_i[1:0] == 2'b11 && !busy_o;

    // operands as they stood when the instruction started
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_ins <= INSTR_RST;
            lat_acc <= ACC_RST;
        end else if (go) begin
            lat_ins <= wb_dat_i[INSTR_W-1:0];
            lat_acc <= acc_o;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("no ack one clock after a taken request");
    a_ack_one_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one clock");
    a_busy_on_start: assert property (go |=> busy_o)
        else $error("busy not raised by an instruction write");
    // ce low freezes the count, so it is left out here
    a_busy_four_clocks: assert property (disable iff (rst_i || !ce_i)
        $rose(busy_o) |-> busy_o [*4] ##1 !busy_o)
        else $error("instruction not four clocks long");
    a_acc_change_cause: assert property ($changed(acc_o) |-> $fell(busy_o) ||
        ($past(take) && $past(wb_we_i) && $past(wb_adr_i) == REG_ACC))
        else $error("accumulator changed without cause");
    a_add_lit_sum: assert property ($fell(busy_o) && lat_ins[13:9] == OPC_ADD_LIT
        |-> acc_o == DATA_W'(lat_acc + lat_ins[7:0]))
        else $error("add literal sum wrong");
    a_and_lit_res: assert property ($fell(busy_o) && lat_ins[13:8] == OPC_AND_LIT
        |-> acc_o == (lat_acc & lat_ins[7:0]))
        else $error("and literal result wrong");
    a_file_keeps_acc: assert property ($fell(busy_o) && lat_ins[DEST_BIT] &&
        (lat_ins[13:8] == OPC_ADD_FILE || lat_ins[13:8] == OPC_AND_FILE) |-> acc_o == lat_acc)
        else $error("file destination touched the accumulator");
    // clock enable low freezes acc_o, busy_o and wb_ack_o
    a_ce_low_freezes: assert property (!ce_i |=> $stable(acc_o) && $stable(busy_o) && $stable(wb_ack_o))
        else $error("state moved while clock enable was low");
endmodule : alo_core_checker

bind alo_core alo_core_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .acc_o(acc_o));

// *** test_add_and_logic_ops.sv ***
/* test_add_and_logic_ops: self-checking bench of alo_core through its wishbone port.
   assumes the port checker is bound to alo_core; 100 ns clock. */
`timescale 1ns/1ps
module test_add_and_logic_ops import alo_pkg::*;;
    localparam logic [7:0] OFFS [5] = '{REG_INSTR, REG_ACC, REG_FLAGS, REG_FILE_PTR, REG_FILE_DATA};
    logic        clk_i, rst_i, ce_i, cyc, stb, we, ack, busy;
    logic [7:0]  adr, acc;
    logic [3:0]  sel;
    logic [31:0] dat, dat_o;
    int          miscompares, n_tests;

    alo_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .busy_o(busy), .acc_o(acc));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // ack is read before the edge's own updates land, as a master samples it
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        q = dat_o;
        // taking edge plus the edge that shows ack
        check("ack edges", 32'h2, n);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : xfer

    task do_op(input logic [13:0] ins, input logic [7:0] a, f, input logic [6:0] p, input logic [2:0] fl,
               input logic [7:0] ea, ef, input logic [3:0] efl);
        logic [31:0] q;
        int n;
        xfer(1'b1, REG_FILE_PTR, {25'h0, p}, q);
        xfer(1'b1, REG_FILE_DATA, {24'h0, f}, q);
        xfer(1'b1, REG_ACC, {24'h0, a}, q);
        xfer(1'b1, REG_FLAGS, {29'h0, fl}, q);
        xfer(1'b1, REG_INSTR, {18'h0, ins}, q);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 20);
        check("exec clocks", 32'h4, n);
        check("acc port", {24'h0, ea}, {24'h0, acc});
        xfer(1'b0, REG_ACC, 32'h0, q);
        check("acc reg", {24'h0, ea}, q);
        xfer(1'b0, REG_FILE_DATA, 32'h0, q);
        check("file reg", {24'h0, ef}, q);
        xfer(1'b0, REG_FLAGS, 32'h0, q);
        check("flags", {28'h0, efl}, {28'h0, q[9], q[2:0]});
    endtask : do_op

    task s_reset;
        logic [31:0] q;
        check("busy", 32'h0, {31'h0, busy});
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, OFFS[i], 32'h0, q);
            check("reset value", 32'h0, q);
        end
        xfer(1'b1, 8'h14, 32'hFF, q);
        xfer(1'b0, 8'h14, 32'h0, q);
        check("unmapped", 32'h0, q);
    endtask : s_reset

    // flags: {unsupported, zero, half carry, carry}
    task s_add_lit;
        do_op(14'h3E15, 8'h10, 8'h00, 7'h00, 3'h7, 8'h25, 8'h00, 4'h0);
        do_op(14'h3F01, 8'hFF, 8'h00, 7'h00, 3'h0, 8'h00, 8'h00, 4'h7);
        do_op(14'h3E08, 8'h08, 8'h00, 7'h00, 3'h5, 8'h10, 8'h00, 4'h2);
        do_op(14'h3EF0, 8'h20, 8'h00, 7'h00, 3'h6, 8'h10, 8'h00, 4'h1);
    endtask : s_add_lit

    task s_and_lit;
        do_op(14'h395F, 8'hA3, 8'h00, 7'h00, 3'h3, 8'h03, 8'h00, 4'h3);
        do_op(14'h3900, 8'hFF, 8'h00, 7'h00, 3'h0, 8'h00, 8'h00, 4'h4);
    endtask : s_and_lit

    task s_add_file;
        do_op(14'h077F, 8'h17, 8'hC2, 7'h7F, 3'h7, 8'hD9, 8'hC2, 4'h0);
        do_op(14'h07FF, 8'hD9, 8'hC2, 7'h7F, 3'h0, 8'hD9, 8'h9B, 4'h1);
        do_op(14'h0785, 8'h80, 8'h80, 7'h05, 3'h0, 8'h80, 8'h00, 4'h5);
    endtask : s_add_file

    task s_and_file;
        do_op(14'h0585, 8'h17, 8'hC2, 7'h05, 3'h3, 8'h17, 8'h02, 4'h3);
        do_op(14'h0505, 8'h01, 8'h02, 7'h05, 3'h1, 8'h00, 8'h02, 4'h5);
        do_op(14'h0A05, 8'h33, 8'h44, 7'h05, 3'h2, 8'h33, 8'h44, 4'hA);
    endtask : s_and_file

    // ce low must hold a running instruction; lane-off and busy writes are dropped
    task s_ce_freeze;
        logic [31:0] q;
        xfer(1'b1, REG_ACC, 32'h10, q);
        sel <= 4'h2;
        xfer(1'b1, REG_ACC, 32'h77, q);
        sel <= 4'hF;
        xfer(1'b1, REG_INSTR, 32'h3E15, q);
        ce_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check("busy frozen", 32'h1, {31'h0, busy});
        check("acc frozen", 32'h10, {24'h0, acc});
        ce_i <= 1'b1;
        xfer(1'b1, REG_ACC, 32'hEE, q);
        @(posedge clk_i);
        check("busy done", 32'h0, {31'h0, busy});
        check("acc result", 32'h25, {24'h0, acc});
    endtask : s_ce_freeze

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        s_reset;
        s_add_lit;
        s_and_lit;
        s_add_file;
        s_and_file;
        s_ce_freeze;
        end_of_test;
    end

    // about 390 clocks are expected
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        end_of_test;
    end
endmodule : test_add_and_logic_ops
